// file: src/ptx_regs.svh
/*
 * Register offsets, field positions, reset values and sizes for the
 * protection link signal and trip transfer block.
 * Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
`ifndef PTX_REGS_SVH
`define PTX_REGS_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define PTX_NSIG 16
`define PTX_NTRIP 4
`define PTX_IW 16
`define PTX_AW 8

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PTX_ADDR_RULE 8'h00
`define PTX_ADDR_TRIPEN 8'h04
`define PTX_ADDR_STAT 8'h08
`define PTX_ADDR_RXSIG 8'h0c
`define PTX_ADDR_CAPT 8'h10
`define PTX_ADDR_CURR 8'h14
`define PTX_ADDR_TRIPCNT 8'h18

// ****************************************************************
// Reset values
// ****************************************************************
`define PTX_RST_RULE 32'h0000_0000
`define PTX_RST_TRIPEN 4'hf

// ****************************************************************
// Field positions
// ****************************************************************
`define PTX_STAT_LINK_LSB 0
`define PTX_STAT_TRIP 2
`define PTX_STAT_SRC_LSB 4
`define PTX_STAT_BAD_LSB 8
`define PTX_SEEN_LSB 16

`endif

// file: src/ptx_pkg.sv
/*
 * Types of the protection link signal and trip transfer block.
 * Assumes ptx_regs.svh supplies the sizes.
 */
`include "ptx_regs.svh"

package ptx_pkg;

	// Per-signal fallback selection, two bits per received signal
	typedef enum logic [1:0] {
		RULE_FIXED0 = 2'h0,
		RULE_FIXED1 = 2'h1,
		RULE_CAPT0 = 2'h2,
		RULE_CAPT1 = 2'h3
	} ptx_rule_e;

	// Link supervision, Gray coded
	typedef enum logic [1:0] {
		LINK_IDLE = 2'h0,
		LINK_UP = 2'h1,
		LINK_LOST = 2'h3
	} ptx_link_e;

	typedef struct packed {
		logic [`PTX_NSIG-1:0] sig;
		logic [`PTX_NTRIP-1:0] trip;
		logic [`PTX_IW-1:0] idiff;
		logic [`PTX_IW-1:0] irest;
	} ptx_frame_s;

	typedef struct packed {
		ptx_link_e link;
		logic [31:0] rules;
		logic [`PTX_NTRIP-1:0] trip_en;
		logic [`PTX_NSIG-1:0] rx_last;
		logic [`PTX_NSIG-1:0] seen;
		logic [`PTX_NTRIP-1:0] rx_trip;
		logic [`PTX_IW-1:0] idiff;
		logic [`PTX_IW-1:0] irest;
		logic [7:0] bad_cnt;
		logic [15:0] trip_cnt;
		logic [`PTX_NSIG-1:0] sig_out;
		logic trip_cmd;
		logic trip_evt;
		logic [`PTX_NTRIP-1:0] trip_src;
		ptx_frame_s tx;
		logic ack;
		logic [31:0] dat;
	} ptx_state_s;

endpackage

// file: src/ptx_top.sv
/*
 * Signal and trip transfer over the protection communication link.
 * Sends sixteen local signals, trip decisions and current values to the
 * peer, applies received values, and falls back per signal when the
 * link is down. Registers sit behind a classic Wishbone slave.
 * Assumes a link framer on the same clock that flags each received
 * frame with a one-cycle valid and a good/bad verdict, reports link
 * state as a level, and samples tx_frame_o whenever it builds a frame.
 */
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "ptx_regs.svh"

module ptx_top
	import ptx_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [`PTX_AW-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Local transmit sources
	input wire logic [`PTX_NSIG-1:0] tx_signal_i,
	input wire logic [`PTX_NTRIP-1:0] tx_trip_i,
	input wire logic [`PTX_IW-1:0] loc_idiff_i,
	input wire logic [`PTX_IW-1:0] loc_irest_i,
	// Link framer
	input wire logic link_active_i,
	input wire logic rx_valid_i,
	input wire logic rx_ok_i,
	input wire ptx_frame_s rx_frame_i,
	output ptx_frame_s tx_frame_o,
	// Received results
	output logic [`PTX_NSIG-1:0] rx_signal_o,
	output logic transfer_trip_command_o,
	output logic [`PTX_NTRIP-1:0] trip_src_o,
	output logic trip_evt_o
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic fb_bit(input ptx_rule_e r, input logic capt,
		input logic seen);
		case (r)
			RULE_FIXED0: fb_bit = 1'b0;
			RULE_FIXED1: fb_bit = 1'b1;
			RULE_CAPT0: fb_bit = seen ? capt : 1'b0;
			RULE_CAPT1: fb_bit = seen ? capt : 1'b1;
			default: fb_bit = 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = dat[8*b +: 8];
			end
		end
		wmerge = r;
	endfunction

	function automatic logic hit(input logic [`PTX_AW-1:0] adr,
		input logic [`PTX_AW-1:0] off);
		hit = (adr[`PTX_AW-1:2] == off[`PTX_AW-1:2]);
	endfunction

	function automatic ptx_rule_e rule_of(input logic [31:0] rules, input int i);
		rule_of = ptx_rule_e'(rules[2*i +: 2]);
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	ptx_state_s st_q;
	ptx_state_s st_d;

	always_comb begin
		logic wr;
		logic take;
		logic link_up;
		logic [31:0] capt_w;
		logic [31:0] en_w;
		wr = 1'b0;
		take = 1'b0;
		link_up = 1'b0;
		capt_w = 32'h0000_0000;
		en_w = 32'h0000_0000;
		st_d = st_q;

		// Single-cycle answer; ack falls the cycle after it rose
		st_d.ack = wb_cyc_i & wb_stb_i & ~st_q.ack;
		wr = st_d.ack & wb_we_i;

		case (st_q.link)
			LINK_IDLE: begin
				if (link_active_i) begin
					st_d.link = LINK_UP;
				end
			end
			LINK_UP: begin
				if (!link_active_i) begin
					st_d.link = LINK_LOST;
				end
			end
			LINK_LOST: begin
				if (link_active_i) begin
					st_d.link = LINK_UP;
				end
			end
			default: begin
				st_d.link = LINK_IDLE;
			end
		endcase
		link_up = (st_d.link == LINK_UP);

		// Register writes
		if (wr && hit(wb_adr_i, `PTX_ADDR_RULE)) begin
			st_d.rules = wmerge(st_q.rules, wb_dat_i, wb_sel_i);
		end
		if (wr && hit(wb_adr_i, `PTX_ADDR_TRIPEN)) begin
			en_w = wmerge({28'h0000000, st_q.trip_en}, wb_dat_i, wb_sel_i);
			st_d.trip_en = en_w[`PTX_NTRIP-1:0];
		end
		if (wr && hit(wb_adr_i, `PTX_ADDR_CAPT)) begin
			// Software restores the saved capture after a restart
			capt_w = wmerge({st_q.seen, st_q.rx_last}, wb_dat_i, wb_sel_i);
			st_d.rx_last = capt_w[`PTX_NSIG-1:0];
			st_d.seen = capt_w[`PTX_SEEN_LSB +: `PTX_NSIG];
		end

		// Frames count only while the link is reported active
		take = rx_valid_i & link_active_i;
		if (take && rx_ok_i) begin
			// A live frame overrides a restore in the same cycle
			st_d.rx_last = rx_frame_i.sig;
			st_d.seen = {`PTX_NSIG{1'b1}};
			st_d.rx_trip = rx_frame_i.trip;
			st_d.idiff = rx_frame_i.idiff;
			st_d.irest = rx_frame_i.irest;
		end else if (take && (st_q.bad_cnt != 8'hff)) begin
			st_d.bad_cnt = st_q.bad_cnt + 8'h01;
		end
		if (!link_up) begin
			st_d.rx_trip = '0;
		end

		// Received signal per bit: live value or fallback
		for (int i = 0; i < `PTX_NSIG; i++) begin
			if (link_up && st_d.seen[i]) begin
				st_d.sig_out[i] = st_d.rx_last[i];
			end else begin
				st_d.sig_out[i] = fb_bit(rule_of(st_d.rules, i), st_d.rx_last[i],
					st_d.seen[i]);
			end
		end

		st_d.trip_src = st_d.rx_trip & st_d.trip_en & {`PTX_NTRIP{link_up}};
		st_d.trip_cmd = |st_d.trip_src;
		st_d.trip_evt = st_d.trip_cmd & ~st_q.trip_cmd;
		if (wr && hit(wb_adr_i, `PTX_ADDR_TRIPCNT)) begin
			st_d.trip_cnt = 16'h0000;
		end
		// Counting wins over a clear in the same cycle
		if (st_d.trip_evt && (st_q.trip_cnt != 16'hffff)) begin
			st_d.trip_cnt = st_q.trip_cnt + 16'h0001;
		end

		// Every cycle carries signals, trips and currents
		st_d.tx.sig = tx_signal_i;
		st_d.tx.trip = tx_trip_i;
		st_d.tx.idiff = loc_idiff_i;
		st_d.tx.irest = loc_irest_i;

		// Read data; unmapped offsets read zero
		st_d.dat = 32'h0000_0000;
		if (hit(wb_adr_i, `PTX_ADDR_RULE)) begin
			st_d.dat = st_q.rules;
		end else if (hit(wb_adr_i, `PTX_ADDR_TRIPEN)) begin
			st_d.dat = {28'h0000000, st_q.trip_en};
		end else if (hit(wb_adr_i, `PTX_ADDR_STAT)) begin
			st_d.dat[`PTX_STAT_LINK_LSB +: 2] = st_q.link;
			st_d.dat[`PTX_STAT_TRIP] = st_q.trip_cmd;
			st_d.dat[`PTX_STAT_SRC_LSB +: `PTX_NTRIP] = st_q.trip_src;
			st_d.dat[`PTX_STAT_BAD_LSB +: 8] = st_q.bad_cnt;
		end else if (hit(wb_adr_i, `PTX_ADDR_RXSIG)) begin
			st_d.dat = {st_q.seen, st_q.sig_out};
		end else if (hit(wb_adr_i, `PTX_ADDR_CAPT)) begin
			st_d.dat = {st_q.seen, st_q.rx_last};
		end else if (hit(wb_adr_i, `PTX_ADDR_CURR)) begin
			st_d.dat = {st_q.irest, st_q.idiff};
		end else if (hit(wb_adr_i, `PTX_ADDR_TRIPCNT)) begin
			st_d.dat = {16'h0000, st_q.trip_cnt};
		end
		if (!st_d.ack) begin
			st_d.dat = st_q.dat;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '0;
			st_q.rules <= `PTX_RST_RULE;
			st_q.trip_en <= `PTX_RST_TRIPEN;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign wb_dat_o = st_q.dat;
	assign wb_ack_o = st_q.ack;
	assign tx_frame_o = st_q.tx;
	assign rx_signal_o = st_q.sig_out;
	assign transfer_trip_command_o = st_q.trip_cmd;
	assign trip_src_o = st_q.trip_src;
	assign trip_evt_o = st_q.trip_evt;

	// ****************************************************************
	// Checks
	// ****************************************************************
	logic bus_wr;
	assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i;

	genvar g;
	generate
		for (g = 0; g < `PTX_NSIG; g++) begin : g_sig_chk
			a_fixed_low: assert property (@(posedge clk_i) disable iff (rst_i)
				(st_q.link != LINK_UP) && (rule_of(st_q.rules, g) == RULE_FIXED0)
				|-> !rx_signal_o[g])
				else $error("fixed-low fallback not zero");
			a_fixed_high: assert property (@(posedge clk_i) disable iff (rst_i)
				(st_q.link != LINK_UP) && (rule_of(st_q.rules, g) == RULE_FIXED1)
				|-> rx_signal_o[g])
				else $error("fixed-high fallback not one");
			a_capt_hold: assert property (@(posedge clk_i) disable iff (rst_i)
				(st_q.link != LINK_UP) && st_q.seen[g] && st_q.rules[2*g+1]
				|-> rx_signal_o[g] == st_q.rx_last[g])
				else $error("captured fallback lost last value");
			a_init_low: assert property (@(posedge clk_i) disable iff (rst_i)
				!st_q.seen[g] && (rule_of(st_q.rules, g) == RULE_CAPT0)
				|-> !rx_signal_o[g])
				else $error("captured init-low not zero");
			a_init_high: assert property (@(posedge clk_i) disable iff (rst_i)
				!st_q.seen[g] && (rule_of(st_q.rules, g) == RULE_CAPT1)
				|-> rx_signal_o[g])
				else $error("captured init-high not one");
			a_live_drive: assert property (@(posedge clk_i) disable iff (rst_i)
				(st_q.link == LINK_UP) && st_q.seen[g]
				|-> rx_signal_o[g] == st_q.rx_last[g])
				else $error("received signal not driven from link");
		end
	endgenerate

	sequence s_good_trip;
		rx_valid_i && rx_ok_i && link_active_i && !bus_wr
			&& ((rx_frame_i.trip & st_q.trip_en) != '0);
	endsequence

	sequence s_trip_rise;
		!transfer_trip_command_o ##1 transfer_trip_command_o;
	endsequence

	a_trip_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		s_good_trip |=> transfer_trip_command_o)
		else $error("remote trip gave no local trip");
	a_trip_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_q.link != LINK_UP) |-> !transfer_trip_command_o && (trip_src_o == '0))
		else $error("trip output active while link down");
	a_trip_record: assert property (@(posedge clk_i) disable iff (rst_i)
		s_trip_rise |-> trip_evt_o ##1 !trip_evt_o)
		else $error("trip event not one pulse at rise");
	a_bad_frame: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_valid_i && !rx_ok_i && link_active_i && !bus_wr
		|=> $stable(st_q.rx_last) && $stable(st_q.rx_trip) && $stable(st_q.idiff))
		else $error("invalid frame changed received values");
	a_frame_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
		!link_active_i && !bus_wr |=> $stable(st_q.rx_last) && (st_q.link != LINK_UP))
		else $error("frame taken while link inactive");
	a_capt_restore: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_wr && !wb_ack_o && (wb_sel_i == 4'hf) && hit(wb_adr_i, `PTX_ADDR_CAPT)
		&& !(rx_valid_i && link_active_i)
		|=> st_q.rx_last == $past(wb_dat_i[`PTX_NSIG-1:0]))
		else $error("capture restore not applied");
	a_tx_copy: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> (tx_frame_o.sig == $past(tx_signal_i))
		&& (tx_frame_o.idiff == $past(loc_idiff_i)) && (tx_frame_o.irest == $past(loc_irest_i)))
		else $error("transmit frame not following sources");
	a_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer not a single cycle pulse");

endmodule

// file: tb/ptx_peer.sv
/*
 * Behavioural peer device at the far end of the protection link.
 * Assumes the bench calls its tasks; outputs change only at rising edges.
 */
`timescale 1ns/1ps

module ptx_peer
	import ptx_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Frames from the local block
	input wire ptx_frame_s tx_frame_i,
	// Link framer side
	output logic link_active_o,
	output logic rx_valid_o,
	output logic rx_ok_o,
	output ptx_frame_s rx_frame_o
);
	ptx_frame_s got_q;

	initial begin
		link_active_o = 1'b0;
		rx_valid_o = 1'b0;
		rx_ok_o = 1'b0;
		rx_frame_o = '0;
	end

	// Peer keeps what the block sends every cycle
	always @(posedge clk_i) begin
		got_q <= tx_frame_i;
	end

	task automatic link(input logic up);
		@(posedge clk_i);
		link_active_o <= up;
	endtask

	// One frame after gap idle cycles; lines scrambled once released
	task automatic send(input ptx_frame_s f, input logic ok, input int gap);
		repeat (gap) @(posedge clk_i);
		@(posedge clk_i);
		rx_valid_o <= 1'b1;
		rx_ok_o <= ok;
		rx_frame_o <= f;
		@(posedge clk_i);
		rx_valid_o <= 1'b0;
		rx_ok_o <= ~ok;
		rx_frame_o <= ~f;
	endtask
endmodule

// file: tb/testbench.sv
/*
 * Self-checking bench for the signal and trip transfer block.
 * Assumes ptx_peer stands in for the far device on the link.
 */
`timescale 1ns/1ps
`include "ptx_regs.svh"

module testbench;
	import ptx_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic [3:0] sel = 4'hf;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic [15:0] tsig = 16'h0;
	logic [3:0] ttrip = 4'h0;
	logic [15:0] tid = 16'h0;
	logic [15:0] tir = 16'h0;
	logic lnk, rv, rok, cmd, evt;
	ptx_frame_s rfr, tfr;
	logic [15:0] rsig;
	logic [3:0] src;
	int err_total = 0;
	int total_checks = 0;

	always #12.5 clk_i = ~clk_i;

	ptx_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.tx_signal_i(tsig), .tx_trip_i(ttrip), .loc_idiff_i(tid), .loc_irest_i(tir),
		.link_active_i(lnk), .rx_valid_i(rv), .rx_ok_i(rok), .rx_frame_i(rfr),
		.tx_frame_o(tfr), .rx_signal_o(rsig), .transfer_trip_command_o(cmd),
		.trip_src_o(src), .trip_evt_o(evt));
	ptx_peer peer (.clk_i(clk_i), .tx_frame_i(tfr), .link_active_o(lnk),
		.rx_valid_o(rv), .rx_ok_o(rok), .rx_frame_o(rfr));

	// ****************************************************************
	// Common tasks
	// ****************************************************************
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Classic single cycle; ack is awaited under a bound
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		sel <= s;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 40);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (ack !== 1'b1) begin
			err_total++;
			stop_test();
		end
	endtask

	task automatic wrb(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] q;
		bus(1'b1, a, d, s, q);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wrb(a, d, 4'hf);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, 4'hf, q);
		chk(q, e);
	endtask

	// Land the edge's updates before looking
	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset;
		rd(`PTX_ADDR_RULE, `PTX_RST_RULE);
		rd(`PTX_ADDR_TRIPEN, {28'h0, `PTX_RST_TRIPEN});
		rd(`PTX_ADDR_STAT, 32'h0);
		wr(8'h3c, 32'hffff_ffff);
		rd(8'h3c, 32'h0);
		chk({rsig, cmd}, 17'h0);
		wrb(`PTX_ADDR_RULE, 32'hffff_ffff, 4'h4);
		rd(`PTX_ADDR_RULE, 32'h00ff_0000);
	endtask

	task automatic t_tx;
		ptx_frame_s e;
		e = {16'hc3a5, 4'h9, 16'h0123, 16'hfedc};
		@(posedge clk_i);
		tsig <= 16'hc3a5;
		ttrip <= 4'h9;
		tid <= 16'h0123;
		tir <= 16'hfedc;
		settle(2);
		chk(tfr, e);
		chk(peer.got_q, e);
	endtask

	// Rules per signal cycle through all four codes
	task automatic t_rx;
		wr(`PTX_ADDR_RULE, 32'he4e4_e4e4);
		peer.link(1'b1);
		settle(3);
		chk(rsig, 16'haaaa);
		peer.send({16'h5a3c, 4'h0, 16'h1234, 16'h8765}, 1'b1, 0);
		@(negedge clk_i);
		chk(rsig, 16'h5a3c);
		peer.send({16'hffff, 4'hf, 16'h0, 16'h0}, 1'b0, 3);
		@(negedge clk_i);
		chk({rsig, cmd}, {16'h5a3c, 1'b0});
		rd(`PTX_ADDR_CURR, 32'h8765_1234);
		peer.link(1'b0);
		settle(3);
		chk(rsig, (16'h5a3c & 16'hcccc) | 16'h2222);
		peer.send({16'h0000, 4'hf, 16'h0, 16'h0}, 1'b1, 0);
		settle(1);
		chk(rsig, (16'h5a3c & 16'hcccc) | 16'h2222);
		wr(`PTX_ADDR_CAPT, 32'hffff_0f0f);
		rd(`PTX_ADDR_CAPT, 32'hffff_0f0f);
		settle(1);
		chk(rsig, (16'h0f0f & 16'hcccc) | 16'h2222);
		rd(`PTX_ADDR_RXSIG, 32'hffff_2e2e);
	endtask

	task automatic t_trip;
		wr(`PTX_ADDR_TRIPEN, 32'h5);
		peer.link(1'b1);
		settle(2);
		peer.send({16'h0, 4'h6, 16'h0, 16'h0}, 1'b1, 0);
		@(negedge clk_i);
		chk({cmd, src, evt}, {1'b1, 4'h4, 1'b1});
		@(negedge clk_i);
		chk(evt, 1'b0);
		peer.send({16'h0, 4'ha, 16'h0, 16'h0}, 1'b1, 0);
		@(negedge clk_i);
		chk({cmd, src}, 5'h0);
		peer.send({16'h0, 4'h1, 16'h0, 16'h0}, 1'b1, 1);
		@(negedge clk_i);
		chk({cmd, src, evt}, {1'b1, 4'h1, 1'b1});
		rd(`PTX_ADDR_TRIPCNT, 32'h2);
		peer.link(1'b0);
		settle(3);
		chk({cmd, src}, 5'h0);
		rd(`PTX_ADDR_STAT, 32'h0000_0103);
		peer.link(1'b1);
		settle(3);
		chk({cmd, src}, 5'h0);
		wr(`PTX_ADDR_TRIPCNT, 32'h0);
		rd(`PTX_ADDR_TRIPCNT, 32'h0);
	endtask

	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_tx();
		t_rx();
		t_trip();
		stop_test();
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		stop_test();
	end
endmodule
